// ===== rtl/mdst_ctl_if.sv
`timescale 1ns/1ps
interface mdst_ctl_if;
  logic dclk_inv;
  logic dclk_dly_off;
  logic [3:0] tolerance;
  logic [1:0] chk_mode;
  logic [3:0] dclk_dly;
  logic [2:0] sout_rate;
  logic [2:0] sin_rate;
  logic [3:0] sync_dly;
  logic master_en;
  logic slave_en;
  logic sync_err_set;
  logic data_err_set;

  modport regs (
    output dclk_inv, dclk_dly_off, tolerance, chk_mode, dclk_dly,
    output sout_rate, sin_rate, sync_dly, master_en, slave_en,
    input sync_err_set, data_err_set
  );
  modport core (
    input dclk_inv, dclk_dly_off, tolerance, chk_mode, dclk_dly,
    input sout_rate, sin_rate, sync_dly, master_en, slave_en,
    output sync_err_set, data_err_set
  );
endinterface : mdst_ctl_if

// ===== rtl/mdst_defines.svh
`ifndef MDST_DEFINES_SVH
`define MDST_DEFINES_SVH

// register offsets
`define MDST_OFF_DCLK_POL 8'h02
`define MDST_OFF_TIMING_CHK 8'h03
`define MDST_OFF_DLY_SOUT 8'h04
`define MDST_OFF_SIN_RATE 8'h05
`define MDST_OFF_SIN_DLY 8'h06
`define MDST_OFF_ROLES 8'h07
`define MDST_OFF_IRQ_STAT 8'h19

// field positions
`define MDST_DCLK_INV_BIT 2
`define MDST_DCLK_DLY_OFF_BIT 4
`define MDST_TOL_LSB 0
`define MDST_CHK_MODE_LSB 6
`define MDST_SOUT_RATE_LSB 1
`define MDST_DCLK_DLY_LSB 4
`define MDST_SIN_RATE_LSB 1
`define MDST_SIN_DLY_LSB 0
`define MDST_MASTER_BIT 6
`define MDST_SLAVE_BIT 7
`define MDST_IRQ_DATA_BIT 5
`define MDST_IRQ_SYNC_BIT 6

// reset values
`define MDST_RST_CTRL 8'h00
`define MDST_RST_SIN_RATE 8'h00
`define MDST_RST_STAT 8'h00

// codes and timing counts
`define MDST_CHK_DISABLED 2'b00
`define MDST_INT_SYNC_LAST 5'h1F
`define MDST_DCLK_TAPS 16

`endif

// ===== rtl/mdst_pkg.sv
package mdst_pkg;
  // interpolation factor: 1, 2, 4 or 8 converter cycles per input sample
  typedef enum logic [1:0] {
    MDST_INTERP_1,
    MDST_INTERP_2,
    MDST_INTERP_4,
    MDST_INTERP_8
  } mdst_interp_t;

  typedef enum logic {
    MDST_RX_HUNT,
    MDST_RX_LOCKED
  } mdst_rx_state_t;
endpackage : mdst_pkg

// ===== rtl/mdst_regs.sv
`timescale 1ns/1ps
`include "mdst_defines.svh"
module mdst_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // toward the timing core
  mdst_ctl_if.regs ctl
);
  logic [7:0] pol_reg, chk_reg, dly_sout_reg, sin_rate_reg, sin_dly_reg, roles_reg, stat_reg;
  logic [7:0] next_stat;
  logic [7:0] stat_set;
  logic [7:0] stat_clr;
  logic [7:0] rd_mux;

  wire wr_stat = reg_write && (reg_addr == `MDST_OFF_IRQ_STAT);

  assign stat_set = {1'b0, ctl.sync_err_set, ctl.data_err_set, 5'h00};
  // write one to clear; a flag raised in the clearing cycle survives
  assign stat_clr = wr_stat ? reg_wdata : 8'h00;
  assign next_stat = (stat_reg & ~stat_clr) | stat_set;

  assign rd_mux = (reg_addr == `MDST_OFF_DCLK_POL) ? pol_reg :
                  (reg_addr == `MDST_OFF_TIMING_CHK) ? chk_reg :
                  (reg_addr == `MDST_OFF_DLY_SOUT) ? dly_sout_reg :
                  (reg_addr == `MDST_OFF_SIN_RATE) ? sin_rate_reg :
                  (reg_addr == `MDST_OFF_SIN_DLY) ? sin_dly_reg :
                  (reg_addr == `MDST_OFF_ROLES) ? roles_reg :
                  (reg_addr == `MDST_OFF_IRQ_STAT) ? stat_reg : 8'h00;

  assign ctl.dclk_inv = pol_reg[`MDST_DCLK_INV_BIT];
  assign ctl.dclk_dly_off = pol_reg[`MDST_DCLK_DLY_OFF_BIT];
  assign ctl.tolerance = chk_reg[`MDST_TOL_LSB +: 4];
  assign ctl.chk_mode = chk_reg[`MDST_CHK_MODE_LSB +: 2];
  assign ctl.sout_rate = dly_sout_reg[`MDST_SOUT_RATE_LSB +: 3];
  assign ctl.dclk_dly = dly_sout_reg[`MDST_DCLK_DLY_LSB +: 4];
  assign ctl.sin_rate = sin_rate_reg[`MDST_SIN_RATE_LSB +: 3];
  assign ctl.sync_dly = sin_dly_reg[`MDST_SIN_DLY_LSB +: 4];
  assign ctl.master_en = roles_reg[`MDST_MASTER_BIT];
  assign ctl.slave_en = roles_reg[`MDST_SLAVE_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pol_reg <= `MDST_RST_CTRL;
      chk_reg <= `MDST_RST_CTRL;
      dly_sout_reg <= `MDST_RST_CTRL;
      sin_rate_reg <= `MDST_RST_SIN_RATE;
      sin_dly_reg <= `MDST_RST_CTRL;
      roles_reg <= `MDST_RST_CTRL;
    end else if (reg_write) begin
      if (reg_addr == `MDST_OFF_DCLK_POL) pol_reg <= reg_wdata;
      if (reg_addr == `MDST_OFF_TIMING_CHK) chk_reg <= reg_wdata;
      if (reg_addr == `MDST_OFF_DLY_SOUT) dly_sout_reg <= reg_wdata;
      if (reg_addr == `MDST_OFF_SIN_RATE) sin_rate_reg <= reg_wdata;
      if (reg_addr == `MDST_OFF_SIN_DLY) sin_dly_reg <= reg_wdata;
      if (reg_addr == `MDST_OFF_ROLES) roles_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_reg <= `MDST_RST_STAT;
      reg_rdata <= 8'h00;
    end else begin
      stat_reg <= next_stat;
      reg_rdata <= reg_read ? rd_mux : reg_rdata;
    end
  end
endmodule : mdst_regs

// ===== rtl/mdst_sync_timing.sv
// What this block does
// - sync driver enable bit makes the device master, driving sync output pair.
// - sync receiver enable bit makes the device accept the sync input.
// - master sync output rate is sample clock over a field-selected integer.
// - three-bit field tells the receiver the incoming sync rate, 32 down to 2.
// - incoming sync sampled on sample clock gives internal sync every 32 cycles.
// - surplus faster sync pulses are discarded, one kept per internal period.
// - per-input-sample clock is sample clock over interpolation, phased by sync.
// - four-bit sync delay offsets sample clock alignment from internal sync.
// - sync timing errors are detected and latched as a status flag.
// - timing check mode 00 turns off input data timing error checking.
// - four-bit data clock delay shifts the data clock output.
`timescale 1ns/1ps
`include "mdst_defines.svh"
module mdst_sync_timing (
  // converter sample clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // datapath configuration
  input wire mdst_pkg::mdst_interp_t interp_sel,
  // data timing monitor, same clock
  input wire logic data_timing_err,
  // sync input pin (differential receiver outside)
  input wire logic sync_in,
  // sync output pair
  output logic sync_out_p,
  output logic sync_out_n,
  output logic sync_out_en,
  // derived clocks and events
  output logic input_sample_clock,
  output logic input_sample_tick,
  output logic data_clock_output,
  output logic internal_sync,
  output logic sync_locked
);
  import mdst_pkg::*;

  mdst_ctl_if ctl ();

  mdst_regs u_regs (
    .clk(clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .ctl(ctl.regs)
  );

  // period mask for a rate code: 000 is /32 down to 100 is /2
  function automatic logic [4:0] rate_mask(input logic [2:0] code);
    logic [4:0] m;
    m = 5'h1F;
    case (code)
      3'h0: m = 5'h1F;
      3'h1: m = 5'h0F;
      3'h2: m = 5'h07;
      3'h3: m = 5'h03;
      3'h4: m = 5'h01;
      // undefined codes fall back to the slowest rate
      default: m = 5'h1F;
    endcase
    return m;
  endfunction : rate_mask

  // sync receiver: two-flop synchroniser, edge detect and 32-cycle period
  logic sync_meta;
  logic sync_s;
  logic sync_prev;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_meta <= 1'b0;
      sync_s <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_meta <= sync_in;
      sync_s <= sync_meta;
      sync_prev <= sync_s;
    end
  end

  // the master must also hear its own looped-back pulse
  wire rx_on = ctl.slave_en | ctl.master_en;
  // a one-cycle-high pulse still shows as exactly one rising edge
  wire rx_edge = rx_on & sync_s & ~sync_prev;

  mdst_rx_state_t rx_state;
  mdst_rx_state_t next_rx_state;
  logic [4:0] sync_cnt;
  logic [4:0] next_sync_cnt;
  logic next_internal_sync;

  wire [4:0] in_mask = rate_mask(ctl.sin_rate);
  // an edge arrives while sync_cnt still shows the cycle before the wrap,
  // so the expected-edge test looks one count ahead
  wire [4:0] phase_ahead = 5'(sync_cnt + 5'h01);
  wire edge_due = (phase_ahead & in_mask) == 5'h00;
  wire locked = (rx_state == MDST_RX_LOCKED);

  always_comb begin
    next_rx_state = rx_state;
    next_sync_cnt = sync_cnt;
    next_internal_sync = 1'b0;
    case (rx_state)
      MDST_RX_HUNT: begin
        if (rx_edge) begin
          next_rx_state = MDST_RX_LOCKED;
          next_sync_cnt = 5'h00;
          next_internal_sync = 1'b1;
        end
      end
      MDST_RX_LOCKED: begin
        // free-running 32-cycle period; extra edges only feed the checker
        next_sync_cnt = phase_ahead;
        next_internal_sync = (sync_cnt == `MDST_INT_SYNC_LAST);
        if (!rx_on) begin
          next_rx_state = MDST_RX_HUNT;
          next_internal_sync = 1'b0;
        end
      end
      default: begin
        next_rx_state = MDST_RX_HUNT;
        next_sync_cnt = 5'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state <= MDST_RX_HUNT;
      sync_cnt <= 5'h00;
      internal_sync <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      sync_cnt <= next_sync_cnt;
      internal_sync <= next_internal_sync;
    end
  end

  // lock holds while either enable stays set; clearing both sends the receiver hunting
  assign sync_locked = locked;

  // an edge off its expected phase, or a missing one, is a timing error
  assign ctl.sync_err_set = rx_on & locked & (rx_edge ^ edge_due);

  // sync delay and per-input-sample divider
  logic dly_armed;
  logic [3:0] dly_cnt;

  // a new internal sync re-arms the delay; a delay of 15 still ends before the next sync
  wire dly_zero = (ctl.sync_dly == 4'h0);
  wire restart = (internal_sync & dly_zero) | (dly_armed & (dly_cnt == 4'h0));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_armed <= 1'b0;
      dly_cnt <= 4'h0;
    end else if (internal_sync && !dly_zero) begin
      dly_armed <= 1'b1;
      dly_cnt <= 4'(ctl.sync_dly - 4'h1);
    end else if (dly_armed) begin
      dly_armed <= (dly_cnt != 4'h0);
      dly_cnt <= 4'(dly_cnt - 4'h1);
    end
  end

  // the divider free-runs between syncs, so it keeps its phase if sync stops
  logic [2:0] smp_cnt;
  logic [2:0] next_smp_cnt;
  logic [2:0] smp_last;
  logic [2:0] smp_half;

  always_comb begin
    smp_last = 3'h0;
    smp_half = 3'h1;
    case (interp_sel)
      MDST_INTERP_1: begin
        smp_last = 3'h0;
        smp_half = 3'h1;
      end
      MDST_INTERP_2: begin
        smp_last = 3'h1;
        smp_half = 3'h1;
      end
      MDST_INTERP_4: begin
        smp_last = 3'h3;
        smp_half = 3'h2;
      end
      MDST_INTERP_8: begin
        smp_last = 3'h7;
        smp_half = 3'h4;
      end
      default: begin
        smp_last = 3'h0;
        smp_half = 3'h1;
      end
    endcase
  end

  // restart puts every synchronized device on phase zero together
  assign next_smp_cnt = restart ? 3'h0 :
                        (smp_cnt >= smp_last) ? 3'h0 : 3'(smp_cnt + 3'h1);
  wire next_smp_clk = (next_smp_cnt < smp_half);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      smp_cnt <= 3'h0;
      input_sample_clock <= 1'b0;
      input_sample_tick <= 1'b0;
    end else begin
      smp_cnt <= next_smp_cnt;
      input_sample_clock <= next_smp_clk;
      input_sample_tick <= (next_smp_cnt == 3'h0);
    end
  end

  // data clock output
  // delay is in whole converter cycles here; finer steps need an analog line
  logic [`MDST_DCLK_TAPS-1:0] dclk_pipe;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dclk_pipe <= '0;
    end else begin
      dclk_pipe <= {dclk_pipe[`MDST_DCLK_TAPS-2:0], next_smp_clk};
    end
  end

  // a change of tap may cut one data clock phase short; retune while data is idle
  wire dclk_tap = ctl.dclk_dly_off ? next_smp_clk : dclk_pipe[ctl.dclk_dly];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_clock_output <= 1'b0;
    end else begin
      data_clock_output <= dclk_tap ^ ctl.dclk_inv;
    end
  end

  // sync output, driven only as master
  // leaving master mode clears the counter, so a new master starts at phase zero
  logic [4:0] sout_cnt;

  wire [4:0] out_mask = rate_mask(ctl.sout_rate);
  wire [4:0] sout_phase = sout_cnt & out_mask;
  wire sout_high = (sout_phase <= (out_mask >> 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sout_cnt <= 5'h00;
    end else if (!ctl.master_en) begin
      sout_cnt <= 5'h00;
    end else begin
      sout_cnt <= 5'(sout_cnt + 5'h01);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_out_p <= 1'b0;
      sync_out_n <= 1'b0;
      sync_out_en <= 1'b0;
    end else begin
      sync_out_en <= ctl.master_en;
      sync_out_p <= ctl.master_en & sout_high;
      sync_out_n <= ctl.master_en & ~sout_high;
    end
  end

  // input data timing check
  // tolerance counts consecutive bad samples let through before flagging
  logic [3:0] err_run;

  wire chk_on = (ctl.chk_mode != `MDST_CHK_DISABLED);
  wire run_full = (err_run == ctl.tolerance);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_run <= 4'h0;
    end else if (!chk_on || !data_timing_err) begin
      err_run <= 4'h0;
    end else if (!run_full) begin
      err_run <= 4'(err_run + 4'h1);
    end
  end

  // a saturated run flags again on every further bad sample
  assign ctl.data_err_set = chk_on & data_timing_err & run_full;

endmodule : mdst_sync_timing

// ===== test/mdst_sync_src.sv
`timescale 1ns/1ps
module mdst_sync_src (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic [5:0] period,
  // sync pin toward the receiver
  output logic sync_pin
);
  logic [5:0] cnt;
  // one-cycle pulse: the shortest the receiver must accept, and it works at period 2
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 6'h00;
      sync_pin <= 1'b0;
    end else if (!run) begin
      cnt <= 6'h00;
      sync_pin <= 1'b0;
    end else begin
      cnt <= (cnt >= period - 6'h01) ? 6'h00 : cnt + 6'h01;
      sync_pin <= (cnt == 6'h00);
    end
  end
endmodule : mdst_sync_src

// ===== test/mdst_sync_timing_assertions.sv
`timescale 1ns/1ps
module mdst_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // observed ports
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire mdst_pkg::mdst_interp_t interp_sel,
  input wire logic sync_out_p,
  input wire logic sync_out_n,
  input wire logic sync_out_en,
  input wire logic input_sample_clock,
  input wire logic input_sample_tick,
  input wire logic internal_sync,
  input wire logic sync_locked
);
  import mdst_pkg::*;
  logic [5:0] gap;
  logic seen;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // gap counts cycles since the last internal sync pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap <= 6'h00;
      seen <= 1'b0;
    end else begin
      gap <= internal_sync ? 6'h00 : gap + 6'h01;
      seen <= (seen & sync_locked) | internal_sync;
    end
  end
  a_out_pair: assert property (sync_out_en |-> sync_out_p != sync_out_n)
    else $error("sync output pair not complementary");
  a_out_idle: assert property (!sync_out_en |-> !sync_out_p && !sync_out_n)
    else $error("sync output pair driven while disabled");
  a_sync_single: assert property (internal_sync |=> !internal_sync)
    else $error("internal sync longer than one cycle");
  a_sync_period: assert property (seen && sync_locked |-> internal_sync == (gap == 6'h1F))
    else $error("internal sync period not 32");
  a_lock_pulse: assert property ($rose(sync_locked) |-> internal_sync || $past(internal_sync))
    else $error("lock without internal sync");
  a_tick_clock: assert property (input_sample_tick |-> input_sample_clock)
    else $error("sample tick while sample clock low");
  a_tick_full: assert property (interp_sel == MDST_INTERP_1 && $stable(interp_sel) &&
    $past(interp_sel, 2) == MDST_INTERP_1 && $past(reset_n, 3) |-> input_sample_tick)
    else $error("sample tick missing at unit interpolation");
  a_rdata_hold: assert property (!$past(reg_read) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  c_sync: cover property (internal_sync);
  c_master: cover property (sync_out_en && sync_out_p);
  c_tick8: cover property (interp_sel == MDST_INTERP_8 && input_sample_tick);
endmodule : mdst_sva

bind mdst_sync_timing mdst_sva u_sva (.clk(clk), .reset_n(reset_n), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .interp_sel(interp_sel), .sync_out_p(sync_out_p),
  .sync_out_n(sync_out_n), .sync_out_en(sync_out_en), .input_sample_clock(input_sample_clock),
  .input_sample_tick(input_sample_tick), .internal_sync(internal_sync),
  .sync_locked(sync_locked));

// ===== test/test_multi_dac_sync_timing.sv
`timescale 1ns/1ps
module test_multi_dac_sync_timing;
  import mdst_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  mdst_interp_t interp_sel = MDST_INTERP_1;
  logic data_timing_err = 1'b0;
  logic sync_in, sync_out_p, sync_out_n, sync_out_en, input_sample_clock;
  logic input_sample_tick, data_clock_output, internal_sync, sync_locked;
  logic src_run = 1'b0;
  logic [5:0] src_period = 6'h20;
  int err_total = 0;
  int num_checks = 0;
  logic [7:0] exp_q[$];
  logic [7:0] adr_q[$];
  logic rd_seen = 1'b0;
  logic [16:0] hist = 17'h00000;
  logic [7:0] regs [7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h19};
  int dly [3] = '{0, 5, 15};

  always #10 clk = ~clk;

  mdst_sync_timing uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .interp_sel(interp_sel), .data_timing_err(data_timing_err),
    .sync_in(sync_in), .sync_out_p(sync_out_p), .sync_out_n(sync_out_n),
    .sync_out_en(sync_out_en), .input_sample_clock(input_sample_clock),
    .input_sample_tick(input_sample_tick), .data_clock_output(data_clock_output),
    .internal_sync(internal_sync), .sync_locked(sync_locked));
  mdst_sync_src u_src (.clk(clk), .reset_n(reset_n), .run(src_run), .period(src_period),
    .sync_pin(sync_in));

  task chk(input string name, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", name, e, g);
      err_total++;
    end
  endtask : chk

  task test_done;
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    adr_q.push_back(a);
    @(posedge clk);
    reg_read <= 1'b0;
  endtask : rd

  task burst(input int n);
    repeat (n) @(posedge clk) data_timing_err <= 1'b1;
    @(posedge clk) data_timing_err <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : burst

  task out_level(input logic v, inout int n);
    for (int k = 0; k < 70 && sync_out_p !== v; k++) begin
      @(negedge clk);
      n++;
    end
  endtask : out_level

  task sync_gap(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (internal_sync !== 1'b1 && n < 70);
  endtask : sync_gap

  // read data is one cycle after the read edge, so compare on the next falling edge
  always @(posedge clk) rd_seen <= reg_read;
  always @(negedge clk) begin
    hist <= {hist[15:0], input_sample_clock};
    if (rd_seen)
      chk($sformatf("reg %h", adr_q.pop_front()), exp_q.pop_front(), reg_rdata);
  end

  initial begin
    int i, n, d, r;
    i = $urandom(32'h5AB1);
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (i = 0; i < 7; i++) rd(regs[i], 8'h00);
    for (i = 0; i < 6; i++) begin
      r = $urandom;
      wr(regs[i], r[7:0]);
      rd(regs[i], r[7:0]);
      wr(regs[i], 8'h00);
    end
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    wr(8'h07, 8'h40);
    for (r = 0; r < 8; r++) begin
      wr(8'h04, 8'(r << 1));
      n = 0;
      out_level(1'b0, n);
      out_level(1'b1, n);
      n = 0;
      out_level(1'b0, n);
      out_level(1'b1, n);
      chk("sync out period", 8'((r > 4) ? 32 : (32 >> r)), 8'(n));
      chk("sync out enable", 8'h01, {7'h00, sync_out_en});
    end
    wr(8'h07, 8'h00);
    repeat (3) @(negedge clk);
    chk("sync out enable", 8'h00, {7'h00, sync_out_en});
    for (r = 0; r < 5; r++) begin
      wr(8'h05, 8'(r << 1));
      src_period <= 6'(32 >> r);
      src_run <= 1'b1;
      wr(8'h07, 8'h80);
      sync_gap(n);
      sync_gap(n);
      chk("internal sync period", 8'h20, 8'(n));
      chk("sync locked", 8'h01, {7'h00, sync_locked});
      rd(8'h19, 8'h00);
      wr(8'h07, 8'h00);
      src_run <= 1'b0;
    end
    src_period <= 6'd24;
    src_run <= 1'b1;
    wr(8'h05, 8'h00);
    wr(8'h07, 8'h80);
    repeat (100) @(posedge clk);
    rd(8'h19, 8'h40);
    wr(8'h07, 8'h00);
    src_run <= 1'b0;
    wr(8'h19, 8'h40);
    rd(8'h19, 8'h00);
    src_period <= 6'h20;
    src_run <= 1'b1;
    wr(8'h07, 8'h80);
    for (r = 0; r < 3; r++) begin
      d = dly[r];
      wr(8'h06, 8'(d));
      interp_sel <= mdst_interp_t'(2'(r + 1));
      sync_gap(n);
      sync_gap(n);
      for (i = 1; i <= 8; i++) begin
        @(negedge clk);
        chk("sample tick", 8'(((i + 31 - d) % (2 << r)) == 0), {7'h00, input_sample_tick});
      end
    end
    wr(8'h07, 8'h00);
    src_run <= 1'b0;
    wr(8'h03, 8'h0F);
    burst(20);
    rd(8'h19, 8'h00);
    for (i = 15; i > 13; i--) begin
      wr(8'h03, 8'h40 | 8'(i));
      burst(i);
      rd(8'h19, 8'h00);
      burst(i + 1);
      rd(8'h19, 8'h20);
      wr(8'h19, 8'h20);
      rd(8'h19, 8'h00);
    end
    // sweep delay under both polarities, then the bypassed path
    for (i = 0; i < 34; i++) begin
      d = i % 16;
      r = (i / 16) % 2;
      wr(8'h02, 8'((r << 2) | ((i / 32) << 4)));
      wr(8'h04, 8'(d << 4));
      repeat (20) @(negedge clk);
      for (n = 0; n < 16; n++) begin
        @(negedge clk);
        if (i < 32)
          chk("data clock", {7'h00, hist[d] ^ r[0]}, {7'h00, data_clock_output});
        else
          chk("data clock", {7'h00, input_sample_clock ^ r[0]}, {7'h00, data_clock_output});
      end
    end
    test_done;
  end

  initial begin
    #1000000;
    err_total++;
    test_done;
  end
endmodule : test_multi_dac_sync_timing
